/* adp_top.sv */
// Converter digital port, result registers and conversion sequencer behind APB
// Behaviour
// [R1] Buffer enable bit 1 connects a pin's digital buffer; 0 disconnects it. Code keeps the selected trigger pin's buffer connected even with its bit 0.
// [R2] Pin level reads pin when buffer enabled or pin is selected trigger input.
// [R3] Disabled, non-trigger channel reads pin level 1.
// [R4] Reset sets every pin level bit to 1.
// [R5] Pin level port readable any time; writes change nothing.
// [R6] Eight result registers, read-only in normal operation.
// [R7] Results justified left or right and signed or unsigned by controls.
// [R8] Two's complement only when left justified; right justified stays unsigned.
// [R9] Result writes take effect only in special mode.
// [R10] Left justified low byte holds bit 1 at 7, bit 0 at 6, rest zero.
// [R11] Resolution 8 or 10 bits by successive approximation search.
// [R12] Exactly one of 8 channels routed to sample-and-hold per conversion; a control write can switch it mid-conversion.
// [R13] Sampling: fast charge via amplifier, then direct input connection.
// [R14] Sample-and-hold clocks gated off when not sampling.
// [R15] Conversion clocks gated off when no conversion runs.
// [R16] Power-up control governs digital clocks and analog power together.
// [R17] Power-up control resets to zero: powered down after reset.
// [R18] Clearing power-up aborts conversion; registers stay accessible.
// [R19] Right justified result sits in low bits, upper bits zero.
`timescale 1ns/1ps
`default_nettype none
`include "adp_params.svh"

module adp_top #(
	parameter int NUM_CH = 8,
	parameter logic [3:0] FAST_CYC = `ADP_FAST_CYC,
	parameter logic [3:0] DIRECT_CYC = `ADP_DIRECT_CYC
) (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Chip mode
	input wire logic special_mode,
	// Pads
	input wire logic [7:0] analog_input_pin,
	output logic [7:0] input_buffer_enable,
	// Analog sub-block
	input wire logic comp_above,
	output adp_pkg::adp_analog_s analog
);

	////////////////////////////////////////////////////////////////////////////
	// Elaboration checks

	generate
		if (NUM_CH != 8) begin : g_bad_ch
			$error("adp_top supports exactly eight channels");
		end
		if (FAST_CYC == 4'h0 || DIRECT_CYC == 4'h0) begin : g_bad_cyc
			$error("adp_top sample stage counts must be nonzero");
		end
		// Search end points must give exactly eight and ten trial steps
		if (`ADP_MSB_IDX - `ADP_LSB_IDX_8 != 4'h7) begin : g_bad_res8
			$error("adp_top eight-bit search span is wrong");
		end
		if (`ADP_MSB_IDX - `ADP_LSB_IDX_10 != 4'h9) begin : g_bad_res10
			$error("adp_top ten-bit search span is wrong");
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////////
	// State

	adp_pkg::adp_state_s st_reg;
	adp_pkg::adp_state_s st_next;

	logic [7:0] pin_level_next;
	logic [7:0] trig_pin;
	logic [15:0] res_view [8]; // Unpacked, so each channel process owns its own element
	logic setup_phase;
	logic access_wr;
	logic res_hit;
	logic [2:0] res_idx;
	logic [3:0] lsb_idx;
	logic [31:0] rd_mux;

	// Setup phase captures read data so prdata comes from a flop with no wait
	assign setup_phase = psel & ~penable;
	assign access_wr = psel & penable & pwrite;
	assign res_hit = paddr[`ADP_RES_BASE_MSB:`ADP_RES_BASE_LSB] == `ADP_RES_BASE && paddr[1:0] == 2'h0;
	assign res_idx = paddr[`ADP_RES_IDX_MSB:`ADP_RES_IDX_LSB];
	assign lsb_idx = st_reg.res10 ? `ADP_LSB_IDX_10 : `ADP_LSB_IDX_8;

	////////////////////////////////////////////////////////////////////////////
	// Per-channel pin level and result formatting

	generate
		for (genvar i = 0; i < 8; i++) begin : g_ch
			// Trigger path keeps the buffer alive even with its enable off
			assign trig_pin[i] = st_reg.external_trigger_enable && !st_reg.trigger_source_select
				&& st_reg.trigger_channel_select == 3'(i);
			assign pin_level_next[i] = (st_reg.digital_buffer_enable_bits[i] | trig_pin[i])
				? analog_input_pin[i] : 1'b1; // [R2] [R3]

			// Stored code is 10 bits, 8-bit results live in its top byte
			always_comb begin
				if (st_reg.justify_select) begin
					// Signed request ignored here, plain unsigned code
					if (st_reg.res10) begin
						res_view[i] = {6'h00, st_reg.results[i]}; // [R19] [R8]
					end else begin
						res_view[i] = {8'h00, st_reg.results[i][9:2]}; // [R19] [R8]
					end
				end else begin
					// Left: code bit 1 at low byte bit 7, bit 0 at bit 6
					res_view[i] = {st_reg.results[i], 6'h00}; // [R10]
					if (!st_reg.res10) begin
						res_view[i][7:6] = 2'h0;
					end
					if (st_reg.signed_result_select) begin
						res_view[i][15] = ~st_reg.results[i][9]; // [R8] [R7]
					end
				end
			end
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////////
	// Read data mux

	always_comb begin
		rd_mux = 32'h0000_0000;
		if (res_hit) begin
			rd_mux = {16'h0000, res_view[res_idx]}; // [R6] [R7]
		end else begin
			unique case (paddr)
				`ADP_OFF_CTRL: begin
					rd_mux[`ADP_CTRL_PWR] = st_reg.analog_power_up;
					rd_mux[`ADP_CTRL_JUST] = st_reg.justify_select;
					rd_mux[`ADP_CTRL_SGN] = st_reg.signed_result_select;
					rd_mux[`ADP_CTRL_RES10] = st_reg.res10;
					rd_mux[`ADP_CTRL_CH_MSB:`ADP_CTRL_CH_LSB] = st_reg.channel;
				end
				`ADP_OFF_TRIG: begin
					rd_mux[`ADP_TRIG_EN] = st_reg.external_trigger_enable;
					rd_mux[`ADP_TRIG_SRC] = st_reg.trigger_source_select;
					rd_mux[`ADP_TRIG_CH_MSB:`ADP_TRIG_CH_LSB] = st_reg.trigger_channel_select;
				end
				`ADP_OFF_IEN: begin
					rd_mux[7:0] = st_reg.digital_buffer_enable_bits;
				end
				`ADP_OFF_PINS: begin
					rd_mux[7:0] = st_reg.pin_level_bits; // [R5]
				end
				`ADP_OFF_STAT: begin
					rd_mux[`ADP_STAT_BUSY] = st_reg.fsm != adp_pkg::ADP_IDLE;
					rd_mux[`ADP_STAT_SAMP] = st_reg.fsm == adp_pkg::ADP_SAMPLE_FAST
						|| st_reg.fsm == adp_pkg::ADP_SAMPLE_DIRECT;
					rd_mux[`ADP_STAT_CH_MSB:`ADP_STAT_CH_LSB] = st_reg.channel;
				end
				default: begin
					rd_mux = 32'h0000_0000;
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Next state: bus writes and conversion sequencer

	always_comb begin
		st_next = st_reg;
		st_next.pin_level_bits = pin_level_next; // [R1]
		if (setup_phase) begin
			st_next.prdata = rd_mux;
		end

		// Conversion sequencer
		unique case (st_reg.fsm)
			adp_pkg::ADP_IDLE: begin
				st_next.cnt = 4'h0;
			end
			adp_pkg::ADP_SAMPLE_FAST: begin
				// Amplifier charges the storage node quickly first
				if (st_reg.cnt == FAST_CYC - 4'h1) begin
					st_next.fsm = adp_pkg::ADP_SAMPLE_DIRECT; // [R13]
					st_next.cnt = 4'h0;
				end else begin
					st_next.cnt = st_reg.cnt + 4'h1;
				end
			end
			adp_pkg::ADP_SAMPLE_DIRECT: begin
				// Direct connection settles the sample for accuracy
				if (st_reg.cnt == DIRECT_CYC - 4'h1) begin
					st_next.fsm = adp_pkg::ADP_CONVERT; // [R13]
					st_next.cnt = 4'h0;
					st_next.bit_idx = `ADP_MSB_IDX;
					st_next.trial = `ADP_TRIAL_MID;
				end else begin
					st_next.cnt = st_reg.cnt + 4'h1;
				end
			end
			adp_pkg::ADP_CONVERT: begin
				// Binary search: keep trial bit if sample at or above code
				if (!comp_above) begin
					st_next.trial[st_reg.bit_idx] = 1'b0; // [R11]
				end
				if (st_reg.bit_idx == lsb_idx) begin
					st_next.results[st_reg.channel] = comp_above ? st_reg.trial
						: st_next.trial; // [R11]
					st_next.fsm = adp_pkg::ADP_IDLE;
				end else begin
					st_next.bit_idx = st_reg.bit_idx - 4'h1;
					st_next.trial[st_reg.bit_idx - 4'h1] = 1'b1; // [R11]
				end
			end
		endcase

		// Register writes land in the access phase
		if (access_wr) begin
			if (res_hit) begin
				if (special_mode) begin
					st_next.results[res_idx] = pwdata[9:0]; // [R9]
				end
			end else begin
				unique case (paddr)
					`ADP_OFF_CTRL: begin
						st_next.analog_power_up = pwdata[`ADP_CTRL_PWR];
						st_next.justify_select = pwdata[`ADP_CTRL_JUST];
						st_next.signed_result_select = pwdata[`ADP_CTRL_SGN];
						st_next.res10 = pwdata[`ADP_CTRL_RES10];
						st_next.channel = pwdata[`ADP_CTRL_CH_MSB:`ADP_CTRL_CH_LSB];
						// Start only when powered; a running conversion restarts
						if (pwdata[`ADP_CTRL_START] && pwdata[`ADP_CTRL_PWR]
							&& !st_reg.external_trigger_enable) begin
							st_next.fsm = adp_pkg::ADP_SAMPLE_FAST; // [R12]
							st_next.cnt = 4'h0;
						end
					end
					`ADP_OFF_TRIG: begin
						st_next.external_trigger_enable = pwdata[`ADP_TRIG_EN];
						st_next.trigger_source_select = pwdata[`ADP_TRIG_SRC];
						st_next.trigger_channel_select = pwdata[`ADP_TRIG_CH_MSB:`ADP_TRIG_CH_LSB];
					end
					`ADP_OFF_IEN: begin
						st_next.digital_buffer_enable_bits = pwdata[7:0]; // [R1]
					end
					`ADP_OFF_PINS: begin
						st_next.pin_level_bits = pin_level_next; // [R5]
					end
					default: begin
						st_next.pin_level_bits = pin_level_next;
					end
				endcase
			end
		end

		// Power-down wins over any sequencer step, registers stay writable
		if (!st_next.analog_power_up) begin
			st_next.fsm = adp_pkg::ADP_IDLE; // [R18]
			st_next.cnt = 4'h0;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// State register

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_reg <= '0;
			st_reg.analog_power_up <= 1'b0; // [R17]
			st_reg.pin_level_bits <= `ADP_PINS_RESET; // [R4]
			st_reg.digital_buffer_enable_bits <= `ADP_IEN_RESET;
			st_reg.trigger_channel_select <= `ADP_TRIG_CH_RESET;
			st_reg.fsm <= adp_pkg::ADP_IDLE;
		end else begin
			st_reg <= st_next;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Outputs

	// APB answers with no wait state and never signals an error
	assign pready = 1'b1;
	assign pslverr = 1'b0;
	assign prdata = st_reg.prdata;
	assign input_buffer_enable = st_reg.digital_buffer_enable_bits | trig_pin; // [R1]

	// Analog controls in one process, so the struct has a single driver
	always_comb begin
		analog = '0;
		// Channel follows the control register, one at a time; a control write can change it mid-conversion
		analog.mux_select = st_reg.channel; // [R12]
		analog.sample_fast = st_reg.fsm == adp_pkg::ADP_SAMPLE_FAST; // [R13]
		analog.sample_direct = st_reg.fsm == adp_pkg::ADP_SAMPLE_DIRECT; // [R13]
		// Gated clocks save power; idle machines draw only quiescent current
		analog.sh_clk_en = st_reg.analog_power_up
			&& (st_reg.fsm == adp_pkg::ADP_SAMPLE_FAST || st_reg.fsm == adp_pkg::ADP_SAMPLE_DIRECT); // [R14] [R16]
		analog.conv_clk_en = st_reg.analog_power_up && st_reg.fsm == adp_pkg::ADP_CONVERT; // [R15] [R16]
		// Power-down removes analog bias as well as the clocks
		analog.analog_power = st_reg.analog_power_up; // [R16]
		analog.dac_code = st_reg.trial; // [R11]
	end

endmodule
`default_nettype wire

/* adp_params.svh */
// Offsets, field positions, reset values and counts of the converter port block
`ifndef ADP_PARAMS_SVH
`define ADP_PARAMS_SVH
`define ADP_OFF_CTRL 8'h00
`define ADP_OFF_TRIG 8'h04
`define ADP_OFF_IEN 8'h08
`define ADP_OFF_PINS 8'h0c
`define ADP_OFF_STAT 8'h10
`define ADP_OFF_RES0 8'h20
`define ADP_RES_IDX_LSB 2
`define ADP_RES_IDX_MSB 4
`define ADP_RES_BASE_MSB 7
`define ADP_RES_BASE_LSB 5
`define ADP_RES_BASE 3'h1
`define ADP_CTRL_PWR 0
`define ADP_CTRL_JUST 1
`define ADP_CTRL_SGN 2
`define ADP_CTRL_RES10 3
`define ADP_CTRL_START 4
`define ADP_CTRL_CH_LSB 5
`define ADP_CTRL_CH_MSB 7
`define ADP_TRIG_EN 0
`define ADP_TRIG_SRC 1
`define ADP_TRIG_CH_LSB 2
`define ADP_TRIG_CH_MSB 4
`define ADP_STAT_BUSY 0
`define ADP_STAT_SAMP 1
`define ADP_STAT_CH_LSB 2
`define ADP_STAT_CH_MSB 4
`define ADP_PINS_RESET 8'hff
`define ADP_IEN_RESET 8'h00
`define ADP_TRIG_CH_RESET 3'h7
`define ADP_FAST_CYC 4'h2
`define ADP_DIRECT_CYC 4'h4
`define ADP_MSB_IDX 4'h9
`define ADP_LSB_IDX_10 4'h0
`define ADP_LSB_IDX_8 4'h2
`define ADP_TRIAL_MID 10'h200
`endif

/* adp_pkg.sv */
// Types shared by the converter port block
package adp_pkg;
	typedef enum logic [2:0] {
		ADP_IDLE,
		ADP_SAMPLE_FAST,
		ADP_SAMPLE_DIRECT,
		ADP_CONVERT
	} adp_state_e;
	typedef struct packed {
		logic analog_power_up;
		logic justify_select;
		logic signed_result_select;
		logic res10;
		logic [2:0] channel;
		logic external_trigger_enable;
		logic trigger_source_select;
		logic [2:0] trigger_channel_select;
		logic [7:0] digital_buffer_enable_bits;
		logic [7:0] pin_level_bits;
		adp_state_e fsm;
		logic [3:0] cnt;
		logic [3:0] bit_idx;
		logic [9:0] trial;
		logic [7:0][9:0] results;
		logic [31:0] prdata;
	} adp_state_s;
	typedef struct packed {
		logic [2:0] mux_select;
		logic sample_fast;
		logic sample_direct;
		logic sh_clk_en;
		logic conv_clk_en;
		logic analog_power;
		logic [9:0] dac_code;
	} adp_analog_s;
endpackage

/* adp_properties.sv */
// Concurrent checks on the converter port block ports
`timescale 1ns/1ps
`default_nettype none

module adp_checker #(
	parameter int NUM_CH = 8,
	parameter logic [3:0] FAST_CYC = 4'h2,
	parameter logic [3:0] DIRECT_CYC = 4'h4
) (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Bus answers
	input wire logic pready,
	input wire logic pslverr,
	// Analog controls
	input wire adp_pkg::adp_analog_s analog
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	////////////////////////////////////////////////////////////////////////////////
	// Bus stays answerable whatever the power state
	bus_ready_a: assert property (pready) else $error("pready low");
	bus_err_a: assert property (!pslverr) else $error("pslverr high");

	////////////////////////////////////////////////////////////////////////////////
	// Clock gating; aborts let the windows end early, so power loss is tolerated
	pwr_gate_a: assert property (!analog.analog_power |-> !analog.sh_clk_en && !analog.conv_clk_en)
		else $error("clock enabled while powered down");
	sh_gate_a: assert property (analog.sh_clk_en |-> analog.sample_fast || analog.sample_direct)
		else $error("sample clock outside sampling");
	// Eight-bit runs stop one cycle after the window, ten-bit runs three cycles after
	conv_len_a: assert property ($rose(analog.conv_clk_en) |->
		(analog.conv_clk_en || !analog.analog_power) [*8] ##[1:3] !analog.conv_clk_en)
		else $error("conversion clock window wrong");
	two_stage_a: assert property ($rose(analog.sample_fast) |->
		(analog.sample_fast || !analog.analog_power) [*2] ##1
		(analog.sample_direct || !analog.analog_power) [*4] ##1
		(analog.conv_clk_en || !analog.analog_power))
		else $error("sampling stages out of order");
	dac_start_a: assert property ($rose(analog.conv_clk_en) |-> analog.dac_code == 10'h200)
		else $error("search does not start at midscale");
	mux_hold_a: assert property (analog.conv_clk_en && $past(analog.conv_clk_en) |-> $stable(analog.mux_select))
		else $error("channel changed in conversion");
endmodule

bind adp_top adp_checker #(.NUM_CH(NUM_CH), .FAST_CYC(FAST_CYC), .DIRECT_CYC(DIRECT_CYC)) chk_u (
	.pclk(pclk),
	.presetn(presetn),
	.pready(pready),
	.pslverr(pslverr),
	.analog(analog)
);

`default_nettype wire

/* test_adc_digital_port_and_results.sv */
// Self-checking bench for the converter port block
`timescale 1ns/1ps
`default_nettype none

module test_adc_digital_port_and_results;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, special_mode = 0;
	logic [7:0] paddr = 8'h00, analog_input_pin = 8'h5a, input_buffer_enable;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic pready, pslverr, comp_above;
	logic [9:0] vin = 10'h2c5;
	adp_pkg::adp_analog_s analog;
	int num_errors = 0, n_checks = 0, cyc = 0;

	// Ideal comparator answering within the cycle
	assign comp_above = (vin >= analog.dac_code);

	adp_top dut_u (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.special_mode(special_mode), .analog_input_pin(analog_input_pin),
		.input_buffer_enable(input_buffer_enable), .comp_above(comp_above), .analog(analog)
	);

	initial begin
		forever #10 pclk = ~pclk;
	end

	////////////////////////////////////////////////////////////////////////////////
	// Verdict, comparison and bus tasks
	task end_sim;
		if (num_errors == 0 && n_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	task chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// Request held until pready seen high; read data taken at that edge
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		rd = prdata;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task rchk(input logic [7:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		chk(rd, exp);
	endtask

	// Polls status until busy clears; only the global timeout ends a hang
	task wait_idle;
		rd = 32'h1;
		while (rd[0] !== 1'b0) apb(1'b0, 8'h10, 32'h0);
	endtask

	////////////////////////////////////////////////////////////////////////////////
	// Scenarios
	task t_reset;
		rchk(8'h0c, 32'hff);
		rchk(8'h08, 32'h0);
		rchk(8'h00, 32'h0);
		chk({31'h0, analog.analog_power}, 32'h0);
		rchk(8'h20, 32'h0);
		rchk(8'h04, 32'h1c);
		rchk(8'h14, 32'h0);
	endtask

	// Second reset in mid-run, with power on and buffers enabled
	task t_rerun_reset;
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		t_reset();
	endtask

	task t_pins;
		apb(1'b1, 8'h08, 32'h0f);
		rchk(8'h0c, 32'hfa);
		chk({24'h0, input_buffer_enable}, 32'h0f);
		apb(1'b1, 8'h04, 32'h15);
		rchk(8'h0c, 32'hda);
		chk({24'h0, input_buffer_enable}, 32'h2f);
		apb(1'b1, 8'h04, 32'h17);
		rchk(8'h0c, 32'hfa);
		apb(1'b1, 8'h0c, 32'h0);
		rchk(8'h0c, 32'hfa);
		analog_input_pin <= 8'ha5;
		rchk(8'h0c, 32'hf5);
		apb(1'b1, 8'h04, 32'h0);
	endtask

	// One stored code read back under six of eight formats (no signed 8-bit), formatting being live
	task t_conv;
		logic [31:0] ctl [6];
		logic [31:0] exp [6];
		ctl = '{32'h09, 32'h0b, 32'h0d, 32'h0f, 32'h01, 32'h03};
		exp = '{32'hb140, 32'h2c5, 32'h3140, 32'h2c5, 32'hb100, 32'hb1};
		apb(1'b1, 8'h00, 32'h79);
		wait_idle();
		for (int i = 0; i < 6; i++) begin
			apb(1'b1, 8'h00, ctl[i]);
			rchk(8'h2c, exp[i]);
		end
		apb(1'b1, 8'h00, 32'h31);
		wait_idle();
		apb(1'b1, 8'h00, 32'h03);
		rchk(8'h24, 32'hb1);
		rchk(8'h28, 32'h0);
	endtask

	task t_special;
		apb(1'b1, 8'h00, 32'h0b);
		apb(1'b1, 8'h2c, 32'h123);
		rchk(8'h2c, 32'h2c5);
		special_mode <= 1'b1;
		apb(1'b1, 8'h2c, 32'h123);
		rchk(8'h2c, 32'h123);
		special_mode <= 1'b0;
	endtask

	// Power cleared in mid-conversion, before the result lands
	task t_abort;
		apb(1'b1, 8'h00, 32'h59);
		for (int i = 0; i < 20 && analog.conv_clk_en !== 1'b1; i++) @(posedge pclk);
		chk({31'h0, analog.conv_clk_en}, 32'h1);
		chk({29'h0, analog.mux_select}, 32'h2);
		apb(1'b1, 8'h00, 32'h0a);
		apb(1'b0, 8'h10, 32'h0);
		chk({31'h0, rd[0]}, 32'h0);
		chk({31'h0, analog.analog_power}, 32'h0);
		chk({31'h0, analog.conv_clk_en}, 32'h0);
		rchk(8'h28, 32'h0);
	endtask

	////////////////////////////////////////////////////////////////////////////////
	// Timeout guard, sized well above the few hundred cycles the run needs
	always @(posedge pclk) begin
		cyc++;
		if (cyc == 4000) begin
			num_errors++;
			end_sim();
		end
	end

	initial begin
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		t_reset();
		t_pins();
		t_conv();
		t_special();
		t_rerun_reset();
		t_abort();
		end_sim();
	end
endmodule

`default_nettype wire
